// *** hdl/isf_flag_logic.sv ***
`timescale 1ns/1ps
// What this block does
// - Ten request sources: two pins, three timers, two-wire, display channel, bus-serial, two serial.
// - Pin A is level or edge detected per type bit; its flag raises request.
// - Edge flags clear on vectoring; level flags are not cleared by vectoring.
// - Pin B works as pin A with its own type bit and flag.
// - Converter done can take over pin B request.
// - Timer zero/one overflow sets their flags, except timer zero in split mode 3.
// - Timer zero/one flags clear automatically when serviced.
// - Timer two overflow flag set by hardware, cleared only by software.
// - Timer two external input, gated by its enable, sets the external flag.
// - Two-wire interrupt follows channel-two status bit, cleared by hardware.
// - Display interrupt from status bit, channel-one bit or protocol-switch flag.
// - Only display status bit clears by hardware; the other two need software.
// - Bus-serial interrupt from endpoint, suspend, resume and end-of-packet events.
// - Same-level simultaneous requests resolved by fixed polling order, pin A first.
// - Global enable low blocks all; high lets each source's enable gate it.
// - Flags sampled late each machine cycle, polled at the last phase of the same one.
module isf_flag_logic
    import isf_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // External pins, already synchronous
    input wire logic extRequestA,
    input wire logic extRequestB,
    input wire logic extATypeSelect,
    input wire logic extBTypeSelect,
    // Converter takeover of pin B
    input wire logic adcOwnsExtB,
    input wire logic adcDone,
    // Timer events and control
    input wire logic timerZeroOverflow,
    input wire logic timerZeroSplitMode3,
    input wire logic timerOneOverflow,
    input wire logic timerTwoOverflow,
    input wire logic timerTwoExtInput,
    input wire logic timerTwoExtEnable,
    input wire logic timerTwoOvfClear,
    input wire logic timerTwoExtClear,
    // Peripheral status levels (their own flags)
    input wire logic twowireChan2Intr,
    input wire logic twowireChan1Intr,
    input wire logic ddcChanOneIntr,
    input wire logic protocolSwitchFlag,
    input wire logic [6:0] usbEventFlags,
    input wire logic serialOneIntr,
    input wire logic serialTwoIntr,
    // Enables and priority
    input wire logic globalIrqEnable,
    input wire logic [9:0] srcEnable,
    input wire logic [9:0] srcHighPrio,
    // Core handshake
    input wire logic vectorAck,
    // Outputs
    output logic extARequestFlag,
    output logic extBRequestFlag,
    output logic timerZeroOverflowFlag,
    output logic timerOneOverflowFlag,
    output logic timerTwoOverflowFlag,
    output logic timerTwoExtFlag,
    output logic irqPending,
    output logic [3:0] irqId,
    output logic twowireHwClear,
    output logic ddcHwClear
);
    typedef struct packed {
        logic [3:0] phase;
        logic prevA;
        logic prevB;
        logic prevT2x;
        logic fa;
        logic fb;
        logic ft0;
        logic ft1;
        logic ft2;
        logic fx2;
        logic [9:0] sampled;
        logic pend;
        logic [3:0] id;
        logic twClr;
        logic ddcClr;
    } isf_state_s;

    isf_state_s st_q;
    isf_state_s st_d;
    logic [9:0] liveReq;
    logic [9:0] gatedHi;
    logic [9:0] gatedLo;
    logic [3:0] hiId;
    logic [3:0] loId;
    logic hiAny;
    logic loAny;
    logic pinB;
    logic ackA;
    logic ackB;

    // Core vectoring to one given source; shared by every hardware clear
    function automatic logic ackHits(logic ack, logic [3:0] cur, int src);
        return ack && cur == 4'(src);
    endfunction

    // Takeover: converter drives the pin B path
    assign pinB = adcOwnsExtB ? adcDone : extRequestB;
    assign ackA = ackHits(vectorAck, st_q.id, SRC_EXTA);
    assign ackB = ackHits(vectorAck, st_q.id, SRC_EXTB);

    // Live request vector, one bit per source
    always_comb begin
        liveReq = ISF_RESET_VEC;
        liveReq[SRC_EXTA] = st_q.fa;
        liveReq[SRC_SER2] = serialTwoIntr;
        liveReq[SRC_TMR0] = st_q.ft0;
        liveReq[SRC_TWI] = twowireChan2Intr;
        liveReq[SRC_EXTB] = st_q.fb;
        liveReq[SRC_DDC] = twowireChan1Intr | ddcChanOneIntr | protocolSwitchFlag;
        liveReq[SRC_TMR1] = st_q.ft1;
        liveReq[SRC_USB] = |usbEventFlags;
        liveReq[SRC_SER1] = serialOneIntr;
        liveReq[SRC_TMR2] = st_q.ft2 | st_q.fx2;
    end

    // Gate by enables, split by priority level
    assign gatedHi = globalIrqEnable ? (st_q.sampled & srcEnable & srcHighPrio) : 10'h000;
    assign gatedLo = globalIrqEnable ? (st_q.sampled & srcEnable & ~srcHighPrio) : 10'h000;

    isf_poll_pick uHi (
        .reqVec(gatedHi),
        .pickId(hiId),
        .pickAny(hiAny)
    );
    isf_poll_pick uLo (
        .reqVec(gatedLo),
        .pickId(loId),
        .pickAny(loAny)
    );

    // Next-state: source flags set win over any clear in the same cycle; vector clear wins over sample and poll
    always_comb begin
        st_d = st_q;
        st_d.phase = (st_q.phase == ISF_MC_LAST) ? 4'h0 : st_q.phase + 4'h1;
        st_d.prevA = extRequestA;
        st_d.prevB = pinB;
        st_d.prevT2x = timerTwoExtInput;
        // Pin A: edge flag sticks until vectored, level flag tracks pin
        if (extATypeSelect) begin
            st_d.fa = (extRequestA && !st_q.prevA) || (st_q.fa && !ackA);
        end else begin
            st_d.fa = extRequestA;
        end
        // Pin B mirrors pin A
        if (extBTypeSelect) begin
            st_d.fb = (pinB && !st_q.prevB) || (st_q.fb && !ackB);
        end else begin
            st_d.fb = pinB;
        end
        // Timer zero and one: set on overflow, cleared on service
        st_d.ft0 = (timerZeroOverflow && !timerZeroSplitMode3)
            || (st_q.ft0 && !ackHits(vectorAck, st_q.id, SRC_TMR0));
        st_d.ft1 = timerOneOverflow || (st_q.ft1 && !ackHits(vectorAck, st_q.id, SRC_TMR1));
        // Timer two: software clear only
        st_d.ft2 = timerTwoOverflow || (st_q.ft2 && !timerTwoOvfClear);
        st_d.fx2 = (timerTwoExtEnable && !timerTwoExtInput && st_q.prevT2x)
            || (st_q.fx2 && !timerTwoExtClear);
        // Sample late in the machine cycle, poll at its last phase
        if (st_q.phase == ISF_SAMPLE_PHASE) begin
            st_d.sampled = liveReq;
        end
        if (st_q.phase == ISF_MC_LAST) begin
            st_d.pend = hiAny | loAny;
            st_d.id = hiAny ? hiId : loId;
        end
        // Hardware clear of peripheral status bits on vectoring
        st_d.twClr = ackHits(vectorAck, st_q.id, SRC_TWI);
        st_d.ddcClr = ackHits(vectorAck, st_q.id, SRC_DDC) && twowireChan1Intr;
        // Vector taken: drop request until next poll
        if (vectorAck) begin
            st_d.pend = 1'b0;
            st_d.id = ISF_ID_NONE;
            st_d.sampled[st_q.id] = 1'b0;
        end
    end

    // State register
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            st_q <= '{phase: 4'h0, prevA: 1'b0, prevB: 1'b0, prevT2x: 1'b0, fa: 1'b0,
                fb: 1'b0, ft0: 1'b0, ft1: 1'b0, ft2: 1'b0, fx2: 1'b0,
                sampled: ISF_RESET_VEC, pend: 1'b0, id: ISF_ID_NONE, twClr: 1'b0,
                ddcClr: 1'b0};
        end else begin
            st_q <= st_d;
        end
    end

    // Outputs straight from flops
    assign extARequestFlag = st_q.fa;
    assign extBRequestFlag = st_q.fb;
    assign timerZeroOverflowFlag = st_q.ft0;
    assign timerOneOverflowFlag = st_q.ft1;
    assign timerTwoOverflowFlag = st_q.ft2;
    assign timerTwoExtFlag = st_q.fx2;
    assign irqPending = st_q.pend;
    assign irqId = st_q.id;
    assign twowireHwClear = st_q.twClr;
    assign ddcHwClear = st_q.ddcClr;

    // Checks
    property p_edge_set;
        @(posedge ref_clk) disable iff (rst)
        (extATypeSelect && extRequestA && !st_q.prevA) |=> extARequestFlag;
    endproperty
    a_edge_set: assert property (p_edge_set) else $error("edge A not flagged");

    property p_edge_ack;
        @(posedge ref_clk) disable iff (rst)
        (extATypeSelect && ackA && !(extRequestA && !st_q.prevA)) |=> !extARequestFlag;
    endproperty
    a_edge_ack: assert property (p_edge_ack) else $error("edge A not cleared");

    sequence s_level_held;
        !extBTypeSelect ##1 !extBTypeSelect;
    endsequence

    property p_level;
        @(posedge ref_clk) disable iff (rst)
        s_level_held |-> extBRequestFlag == $past(pinB);
    endproperty
    a_level: assert property (p_level) else $error("level B flag wrong");

    property p_t0_mode3;
        @(posedge ref_clk) disable iff (rst)
        (!timerZeroOverflowFlag && timerZeroSplitMode3) |=> !timerZeroOverflowFlag;
    endproperty
    a_t0_mode3: assert property (p_t0_mode3) else $error("timer zero set in mode 3");

    property p_t1_ack;
        @(posedge ref_clk) disable iff (rst)
        (vectorAck && irqId == 4'(SRC_TMR1) && !timerOneOverflow) |=> !timerOneOverflowFlag;
    endproperty
    a_t1_ack: assert property (p_t1_ack) else $error("timer one not cleared");

    property p_t2_hold;
        @(posedge ref_clk) disable iff (rst)
        (timerTwoOverflowFlag && !timerTwoOvfClear) |=> timerTwoOverflowFlag;
    endproperty
    a_t2_hold: assert property (p_t2_hold) else $error("timer two flag lost");

    property p_t2x;
        @(posedge ref_clk) disable iff (rst)
        (!timerTwoExtEnable && !timerTwoExtFlag) |=> !timerTwoExtFlag;
    endproperty
    a_t2x: assert property (p_t2x) else $error("ext flag set while disabled");

    property p_global;
        @(posedge ref_clk) disable iff (rst)
        (!globalIrqEnable && st_q.phase == ISF_MC_LAST) |=> !irqPending;
    endproperty
    a_global: assert property (p_global) else $error("request while globally off");

    property p_poll_time;
        @(posedge ref_clk) disable iff (rst)
        $rose(irqPending) |-> $past(st_q.phase) == ISF_MC_LAST;
    endproperty
    a_poll_time: assert property (p_poll_time) else $error("poll off phase");

    property p_ack_drop;
        @(posedge ref_clk) disable iff (rst)
        vectorAck |=> !irqPending;
    endproperty
    a_ack_drop: assert property (p_ack_drop) else $error("pending after ack");

    property p_tw_clear;
        @(posedge ref_clk) disable iff (rst)
        (vectorAck && irqId == 4'(SRC_TWI)) |=> twowireHwClear;
    endproperty
    a_tw_clear: assert property (p_tw_clear) else $error("two-wire clear missing");

    property p_ddc_keep;
        @(posedge ref_clk) disable iff (rst)
        (vectorAck && irqId == 4'(SRC_DDC) && !twowireChan1Intr) |=> !ddcHwClear;
    endproperty
    a_ddc_keep: assert property (p_ddc_keep) else $error("display flag cleared");
endmodule

// *** hdl/isf_pkg.sv ***
package isf_pkg;
    // Source indices in fixed polling order, highest first
    localparam int ISF_NSRC = 10;
    localparam int SRC_EXTA = 0;
    localparam int SRC_SER2 = 1;
    localparam int SRC_TMR0 = 2;
    localparam int SRC_TWI = 3;
    localparam int SRC_EXTB = 4;
    localparam int SRC_DDC = 5;
    localparam int SRC_TMR1 = 6;
    localparam int SRC_USB = 7;
    localparam int SRC_SER1 = 8;
    localparam int SRC_TMR2 = 9;
    // Machine cycle is twelve core clocks; flags sampled late in it
    localparam logic [3:0] ISF_MC_LAST = 4'hB;
    localparam logic [3:0] ISF_SAMPLE_PHASE = 4'h9;
    localparam logic [3:0] ISF_ID_NONE = 4'hF;
    localparam logic [9:0] ISF_RESET_VEC = 10'h000;
endpackage

// *** hdl/isf_poll_pick.sv ***
`timescale 1ns/1ps
// Fixed-order pick among sampled, enabled requests
module isf_poll_pick
    import isf_pkg::*;
(
    // Requests
    input wire logic [9:0] reqVec,
    // Winner
    output logic [3:0] pickId,
    output logic pickAny
);
    // Lowest index wins
    always_comb begin
        pickId = ISF_ID_NONE;
        pickAny = 1'b0;
        for (int i = ISF_NSRC - 1; i >= 0; i--) begin
            if (reqVec[i]) begin
                pickId = 4'(i);
                pickAny = 1'b1;
            end
        end
    end
endmodule

// *** sim/isf_core_model.sv ***
`timescale 1ns/1ps
// Stand-in for the core's vector handshake and the two-wire status bit
module isf_core_model (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Core side
    input wire logic ackOn,
    input wire logic irqPending,
    input wire logic [3:0] irqId,
    output logic vectorAck,
    output logic [3:0] ackedId,
    // Two-wire peripheral side
    input wire logic twSet,
    input wire logic twowireHwClear,
    output logic twowireChan2Intr
);
    // One ack per pending; never back to back, the flag clear needs a cycle
    always @(posedge ref_clk) begin
        if (rst) begin
            vectorAck <= 1'b0;
            ackedId <= 4'hF;
            twowireChan2Intr <= 1'b0;
        end else begin
            vectorAck <= ackOn && irqPending && !vectorAck;
            if (ackOn && irqPending && !vectorAck) begin
                ackedId <= irqId;
            end
            // Status bit drops only when the block asks for it
            twowireChan2Intr <= twSet | (twowireChan2Intr & ~twowireHwClear);
        end
    end
endmodule

// *** sim/isf_flag_logic_tb.sv ***
`timescale 1ns/1ps
module isf_flag_logic_tb;
    logic ref_clk, rst, extRequestA, extRequestB, extATypeSelect, extBTypeSelect, adcOwnsExtB;
    logic adcDone, timerZeroOverflow, timerZeroSplitMode3, timerOneOverflow, timerTwoOverflow;
    logic timerTwoExtInput, timerTwoExtEnable, timerTwoOvfClear, timerTwoExtClear;
    logic twowireChan2Intr, twowireChan1Intr, ddcChanOneIntr, protocolSwitchFlag;
    logic serialOneIntr, serialTwoIntr, globalIrqEnable, vectorAck, extARequestFlag;
    logic extBRequestFlag, timerZeroOverflowFlag, timerOneOverflowFlag, timerTwoOverflowFlag;
    logic timerTwoExtFlag, irqPending, twowireHwClear, ddcHwClear, ackOn, twSet;
    logic [6:0] usbEventFlags;
    logic [9:0] srcEnable, srcHighPrio;
    logic [3:0] irqId, ackedId;
    int num_errors, n_tests;

    isf_flag_logic DUT (.ref_clk, .rst, .extRequestA, .extRequestB, .extATypeSelect,
        .extBTypeSelect, .adcOwnsExtB, .adcDone, .timerZeroOverflow, .timerZeroSplitMode3,
        .timerOneOverflow, .timerTwoOverflow, .timerTwoExtInput, .timerTwoExtEnable,
        .timerTwoOvfClear, .timerTwoExtClear, .twowireChan2Intr, .twowireChan1Intr,
        .ddcChanOneIntr, .protocolSwitchFlag, .usbEventFlags, .serialOneIntr, .serialTwoIntr,
        .globalIrqEnable, .srcEnable, .srcHighPrio, .vectorAck, .extARequestFlag,
        .extBRequestFlag, .timerZeroOverflowFlag, .timerOneOverflowFlag,
        .timerTwoOverflowFlag, .timerTwoExtFlag, .irqPending, .irqId, .twowireHwClear,
        .ddcHwClear);
    isf_core_model core (.ref_clk, .rst, .ackOn, .irqPending, .irqId, .vectorAck, .ackedId,
        .twSet, .twowireHwClear, .twowireChan2Intr);

    // Free-running core clock
    always #2.5 ref_clk = ~ref_clk;

    task automatic chk(input string nm, input logic [9:0] seen, input logic [9:0] exp);
        n_tests++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
    endtask

    // Bounded wait for the core's vector, then the vectored source
    task automatic waitAck(input logic [3:0] expId);
        int k;
        k = 0;
        do begin
            @(posedge ref_clk);
            #1;
            k++;
        end while (vectorAck !== 1'b1 && k < 60);
        chk("ackSeen", {9'h0, vectorAck}, 10'h001);
        chk("ackedId", {6'h00, ackedId}, {6'h00, expId});
    endtask

    task automatic tTimers();
        cyc(1); timerOneOverflow <= 1'b1;
        cyc(1); timerOneOverflow <= 1'b0;
        #1 chk("t1Flag", {9'h0, timerOneOverflowFlag}, 10'h001);
        waitAck(4'h6);
        cyc(1); #1 chk("t1Clr", {9'h0, timerOneOverflowFlag}, 10'h000);
        cyc(1); timerZeroSplitMode3 <= 1'b1; timerZeroOverflow <= 1'b1;
        cyc(1); timerZeroOverflow <= 1'b0;
        cyc(1); #1 chk("t0Split", {9'h0, timerZeroOverflowFlag}, 10'h000);
        cyc(1); timerZeroSplitMode3 <= 1'b0;
        timerZeroOverflow <= 1'b1;
        cyc(1);
        timerZeroOverflow <= 1'b0;
        waitAck(4'h2);
        cyc(1);
        #1 chk("t0Clr", {9'h0, timerZeroOverflowFlag}, 10'h000);
    endtask

    task automatic tTimerTwo();
        cyc(1); timerTwoOverflow <= 1'b1;
        cyc(1); timerTwoOverflow <= 1'b0;
        waitAck(4'h9);
        cyc(3); #1 chk("t2Kept", {9'h0, timerTwoOverflowFlag}, 10'h001);
        cyc(1); ackOn <= 1'b0; timerTwoOvfClear <= 1'b1;
        cyc(1); timerTwoOvfClear <= 1'b0; timerTwoExtEnable <= 1'b1; timerTwoExtInput <= 1'b1;
        cyc(1); timerTwoExtInput <= 1'b0;
        cyc(2); #1 chk("t2Clr", {9'h0, timerTwoOverflowFlag}, 10'h000);
        chk("t2Ext", {9'h0, timerTwoExtFlag}, 10'h001);
        cyc(1); timerTwoExtClear <= 1'b1;
        cyc(1); timerTwoExtClear <= 1'b0; ackOn <= 1'b1;
        cyc(30);
    endtask

    task automatic tExtA();
        cyc(1); extATypeSelect <= 1'b1; extRequestA <= 1'b1;
        cyc(1); extRequestA <= 1'b0;
        waitAck(4'h0);
        cyc(1); #1 chk("edgeClr", {9'h0, extARequestFlag}, 10'h000);
        cyc(1); extATypeSelect <= 1'b0; extRequestA <= 1'b1;
        waitAck(4'h0);
        cyc(1); #1 chk("lvlKept", {9'h0, extARequestFlag}, 10'h001);
        waitAck(4'h0);
        cyc(1); extRequestA <= 1'b0;
        cyc(30);
    endtask

    task automatic tPrio();
        cyc(1); ackOn <= 1'b0; serialOneIntr <= 1'b1; extBTypeSelect <= 1'b1;
        adcOwnsExtB <= 1'b1; adcDone <= 1'b1;
        cyc(1); adcDone <= 1'b0;
        cyc(30); #1 chk("adcFlag", {9'h0, extBRequestFlag}, 10'h001);
        chk("lowIdx", {6'h00, irqId}, 10'h004);
        cyc(1); srcHighPrio <= 10'h100;
        cyc(30); #1 chk("hiPrio", {6'h00, irqId}, 10'h008);
        cyc(1); globalIrqEnable <= 1'b0;
        cyc(30); #1 chk("gOff", {9'h0, irqPending}, 10'h000);
        cyc(1); globalIrqEnable <= 1'b1; srcHighPrio <= 10'h000; serialOneIntr <= 1'b0;
        ackOn <= 1'b1; adcOwnsExtB <= 1'b0;
        cyc(40);
    endtask

    task automatic tPeriph();
        cyc(1); twSet <= 1'b1;
        cyc(1); twSet <= 1'b0;
        waitAck(4'h3);
        cyc(2); #1 chk("twClr", {9'h0, twowireChan2Intr}, 10'h000);
        cyc(1); twowireChan1Intr <= 1'b1;
        waitAck(4'h5);
        cyc(1); #1 chk("ddcClr", {9'h0, ddcHwClear}, 10'h001);
        cyc(1);
        twowireChan1Intr <= 1'b0;
        ddcChanOneIntr <= 1'b1;
        waitAck(4'h5);
        cyc(1);
        #1 chk("ddcKeep", {9'h0, ddcHwClear}, 10'h000);
        cyc(1);
        ddcChanOneIntr <= 1'b0;
        cyc(30);
    endtask

    // Bus-serial flag is held by the peripheral until software drops it
    task automatic tUsb();
        cyc(1);
        srcEnable <= 10'h37F;
        usbEventFlags <= 7'h10;
        cyc(30);
        #1 chk("usbOff", {9'h0, irqPending}, 10'h000);
        cyc(1);
        srcEnable <= 10'h3FF;
        waitAck(4'h7);
        cyc(1);
        usbEventFlags <= 7'h00;
        cyc(30);
    endtask

    task automatic final_report();
        if (num_errors == 0 && n_tests > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // Watchdog sized well above the expected run of a few hundred cycles
    initial begin
        #50000;
        num_errors++;
        final_report();
    end

    initial begin
        {ref_clk, extRequestA, extRequestB, extATypeSelect, extBTypeSelect, adcOwnsExtB} = '0;
        {adcDone, timerZeroOverflow, timerZeroSplitMode3, timerOneOverflow} = '0;
        {timerTwoOverflow, timerTwoExtInput, timerTwoExtEnable, timerTwoOvfClear} = '0;
        {timerTwoExtClear, twowireChan1Intr, ddcChanOneIntr, protocolSwitchFlag} = '0;
        {serialOneIntr, serialTwoIntr, usbEventFlags, srcHighPrio, twSet} = '0;
        {rst, globalIrqEnable, ackOn} = 3'h7;
        srcEnable = 10'h3FF;
        num_errors = 0;
        n_tests = 0;
        cyc(12); rst <= 1'b0;
        tTimers();
        tTimerTwo();
        tExtA();
        tPrio();
        tPeriph();
        tUsb();
        final_report();
    end
endmodule
